// [core/adc_result_core.sv]
/*
 * result encoding, result byte pair and input/reference selection
 * register of a 10-bit converter, with done event and interrupt.
 * assumes the analog front end hands over the sampled voltages in
 * millivolts with a start pulse, all on clk_sys_i.
 */
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module adc_result_core
  import adc_result_pkg::*;
#(
  parameter logic [11:0] EXT_REF_MV = 12'd2500,  // voltage on ref pin
  parameter logic [11:0] SUPPLY_MV  = 12'd3300   // analog supply
) (
  input  wire logic                     clk_sys_i,    // system clock
  input  wire logic                     sys_rst_i,    // sync reset, high
  input  wire adc_result_pkg::reg_req_s req_i,        // register request
  output var  logic [adc_result_pkg::DATA_W-1:0] rd_data_o, // read data
  input  wire logic                     conv_start_i, // start pulse
  input  wire adc_result_pkg::sample_s  sample_i,     // held samples
  output var  logic                     conv_busy_o,  // converting
  output var  logic [3:0]               ref_path_o,   // one-hot ref path
  output var  logic                     int_ref_en_o, // internal ref on
  output var  logic [4:0]               chan_o,       // channel in use
  output var  logic                     irq_o         // level interrupt
);
  import adc_result_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0]        sel;       // input/reference select register
    logic [1:0]        ref_act;   // reference held by conversion
    logic [4:0]        chan_act;  // channel held by conversion
    logic              busy;      // division running
    logic              diff;      // conversion is differential
    logic              neg;       // difference was negative
    logic [NUM_W-1:0]  num;       // dividend, shifted out msb first
    logic [MV_W-1:0]   den;       // reference in millivolts
    logic [MV_W:0]     rem;       // partial remainder
    logic [NUM_W-1:0]  quo;       // quotient
    logic [CNT_W-1:0]  cnt;       // division steps left
    logic [CODE_W-1:0] result;    // visible result code
    logic              lock;      // low byte read, pair frozen
    logic              pend;      // result waiting for unlock
    logic [CODE_W-1:0] pend_val;  // waiting result
    logic              sts_done;  // sticky done event
    logic              ena_done;  // done event enable
    logic [7:0]        rd_data;   // read data, one cycle late
    logic [3:0]        ref_path;  // decoded reference path
    logic              int_ref;   // internal reference enable
    logic              irq;       // interrupt level
  } state_s;

  state_s st_r;   // registered state
  state_s st_nxt; // next state

  // ************************************************************
  // functions
  // ************************************************************
  // channel codes 8..29 are differential, the rest single-ended
  // 11110 and 11111 are the two fixed single-ended tail codes
  function automatic logic is_diff(input logic [4:0] ch);
    is_diff = (ch[4:3] == 2'b01) || (ch[4] && (ch[3:1] != 3'b111));
  endfunction

  // gain of a channel code: 10x/200x group, else unity
  function automatic logic [GAIN_W-1:0] gain_of(input logic [4:0] ch);
    if (ch[4:3] == 2'b01) begin
      gain_of = ch[1] ? GAIN_200 : GAIN_10;
    end else begin
      gain_of = GAIN_1;
    end
  endfunction

  // reference voltage of a select value
  function automatic logic [MV_W-1:0] ref_mv(input logic [1:0] rs);
    case (ref_sel_e'(rs))
      REF_EXT_PIN: ref_mv = EXT_REF_MV;
      REF_SUPPLY:  ref_mv = SUPPLY_MV;
      REF_INT_1V1: ref_mv = INT_1V1_MV;
      default:     ref_mv = INT_2V56_MV;
    endcase
  endfunction

  // place the code in the 16-bit pair per adjust bit
  function automatic logic [15:0] align(input logic [9:0] c,
                                        input logic       ladj);
    align = ladj ? {c, 6'h00} : {6'h00, c};
  endfunction

  // ************************************************************
  // next-state logic
  // ************************************************************
  // one process: register port, division, result publication
  always_comb begin
    logic [MV_W-1:0]   mag;     // input magnitude
    logic [MV_W:0]     rem_sh;  // remainder after shift
    logic [CODE_W-1:0] code;    // clamped final code
    logic [15:0]       pair;    // aligned result pair
    logic              fin;     // division completes now
    logic              done_ev; // result published now
    logic [1:0]        ref_use; // reference for a new conversion

    st_nxt  = st_r;
    mag     = '0;
    rem_sh  = '0;
    code    = CODE_ZERO;
    fin     = 1'b0;
    done_ev = 1'b0;
    ref_use = st_r.sel[REF_HI:REF_LO];
    // adjust bit read live, so a change shows at once
    pair    = align(st_r.result, st_r.sel[LADJ_B]);

    // start: latch channel and reference, build the dividend;
    // a start while busy is ignored
    // samples are taken here only; later input changes do not matter
    if (conv_start_i && !st_r.busy) begin
      st_nxt.busy     = 1'b1;
      st_nxt.ref_act  = ref_use;
      st_nxt.chan_act = st_r.sel[CHAN_HI:0];
      st_nxt.den      = ref_mv(ref_use);
      st_nxt.diff     = is_diff(st_r.sel[CHAN_HI:0]);
      st_nxt.rem      = '0;
      st_nxt.quo      = '0;
      st_nxt.cnt      = DIV_STEPS;
      if (st_nxt.diff) begin
        // magnitude of the difference, sign kept aside
        st_nxt.neg = sample_i.neg_mv > sample_i.pos_mv;
        mag = st_nxt.neg ? sample_i.neg_mv - sample_i.pos_mv
                         : sample_i.pos_mv - sample_i.neg_mv;
        // widen both factors before the product: a full-scale
        // difference at 200x gain needs 29 bits
        st_nxt.num = NUM_W'({mag, 9'h000}) *
                     NUM_W'(gain_of(st_r.sel[CHAN_HI:0]));
      end else begin
        st_nxt.neg = 1'b0;
        st_nxt.num = NUM_W'({sample_i.pos_mv, 10'h000});
      end
    end else if (st_r.busy) begin
      // restoring division, one quotient bit per cycle
      // a fixed 32 steps, so latency never depends on the input
      rem_sh     = {st_r.rem[MV_W-1:0], st_r.num[NUM_W-1]};
      st_nxt.num = {st_r.num[NUM_W-2:0], 1'b0};
      if (rem_sh >= {1'b0, st_r.den}) begin
        st_nxt.rem = rem_sh - {1'b0, st_r.den};
        st_nxt.quo = {st_r.quo[NUM_W-2:0], 1'b1};
      end else begin
        st_nxt.rem = rem_sh;
        st_nxt.quo = {st_r.quo[NUM_W-2:0], 1'b0};
      end
      st_nxt.cnt = st_r.cnt - 6'h01;
      if (st_r.cnt == 6'h01) begin
        fin         = 1'b1;
        st_nxt.busy = 1'b0;
      end
    end

    // clamp the quotient into the code range
    if (fin) begin
      if (!st_r.diff) begin
        // unsigned, full scale saturates at all ones
        code = (st_nxt.quo > NUM_W'(SE_MAX)) ? SE_MAX
               : st_nxt.quo[CODE_W-1:0];
      end else if (!st_r.neg) begin
        code = (st_nxt.quo > NUM_W'(DIFF_MAX)) ? DIFF_MAX
               : st_nxt.quo[CODE_W-1:0];
      end else begin
        // negative: two's complement, msb comes out set unless the quotient is zero
        code = (st_nxt.quo >= NUM_W'(DIFF_MIN)) ? DIFF_MIN
               : CODE_W'(~st_nxt.quo[CODE_W-1:0] + 10'h001);
        if (st_nxt.quo == '0) begin
          code = CODE_ZERO;
        end
      end
    end

    // register reads, data shows in the next cycle only
    // a low read freezes the pair; only a high read thaws it
    st_nxt.rd_data = BYTE_ZERO;
    if (req_i.rd) begin
      case (req_i.addr)
        OFS_RES_LO: begin
          st_nxt.rd_data = pair[7:0];
          st_nxt.lock    = 1'b1;
        end
        OFS_RES_HI: begin
          st_nxt.rd_data = pair[15:8];
          st_nxt.lock    = 1'b0;
          // release a parked result now
          if (st_r.pend) begin
            st_nxt.result = st_r.pend_val;
            st_nxt.pend   = 1'b0;
            done_ev       = 1'b1;
          end
        end
        OFS_SEL: st_nxt.rd_data = st_r.sel;
        OFS_STS: begin
          st_nxt.rd_data[EV_DONE] = st_r.sts_done;
          st_nxt.rd_data[EV_BUSY] = st_r.busy;
        end
        OFS_ENA: st_nxt.rd_data[EV_DONE] = st_r.ena_done;
        default: st_nxt.rd_data = BYTE_ZERO; // clear reg and holes
      endcase
    end

    // publish after the read decode, so a low read in the finishing
    // cycle already freezes the pair and a high read in that cycle
    // cannot bring an older parked code back over the new one
    if (fin) begin
      if (st_nxt.lock) begin
        st_nxt.pend     = 1'b1;
        st_nxt.pend_val = code;
      end else begin
        st_nxt.result = code;
        st_nxt.pend   = 1'b0;
        done_ev       = 1'b1;
      end
    end

    // register writes; status is read only, holes ignored
    // a select write mid conversion lands at once, but the running
    // conversion keeps the channel and reference it latched
    if (req_i.wr) begin
      case (req_i.addr)
        // whole byte stored; the fields act where they are used
        OFS_SEL: st_nxt.sel = req_i.wdata;
        OFS_CLR: begin
          if (req_i.wdata[EV_DONE]) begin
            st_nxt.sts_done = 1'b0;
          end
        end
        OFS_ENA: st_nxt.ena_done = req_i.wdata[EV_DONE];
        default: st_nxt.sel = st_r.sel;
      endcase
    end

    // a done event in the clearing cycle wins over the clear
    if (done_ev) begin
      st_nxt.sts_done = 1'b1;
    end

    // reference path follows the select field only while idle,
    // so a running conversion keeps its reference
    if (!st_nxt.busy) begin
      st_nxt.ref_act = st_nxt.sel[REF_HI:REF_LO];
    end
    case (ref_sel_e'(st_nxt.ref_act))
      REF_EXT_PIN: st_nxt.ref_path = 4'h1;
      REF_SUPPLY:  st_nxt.ref_path = 4'h2;
      REF_INT_1V1: st_nxt.ref_path = 4'h4;
      default:     st_nxt.ref_path = 4'h8;
    endcase
    // internal references are off while the pin is the reference
    st_nxt.int_ref = st_nxt.ref_act[1];

    st_nxt.irq = st_nxt.sts_done & st_nxt.ena_done;
  end

  // ************************************************************
  // state register
  // ************************************************************
  // synchronous reset puts everything, select included, to zero, except ref_path, which comes up as 4'h1
  // the struct is cleared whole, so no field comes out unknown
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_r          <= '0;
      st_r.sel      <= SEL_RST;
      st_r.ref_path <= 4'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs, all straight from the state register
  // ************************************************************
  // no logic sits between a state flip-flop and a port
  assign rd_data_o    = st_r.rd_data;
  assign conv_busy_o  = st_r.busy;
  assign ref_path_o   = st_r.ref_path;
  assign int_ref_en_o = st_r.int_ref;
  assign chan_o       = st_r.chan_act;
  assign irq_o        = st_r.irq;

endmodule

`default_nettype wire

// [pkg/adc_result_pkg.sv]
/*
 * constants, register map and carrier structs of the converter result
 * and reference selection block.
 * assumes a byte-wide register port on the system clock.
 */
package adc_result_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned ADDR_W = 8;   // register address width
  localparam int unsigned DATA_W = 8;   // register data width
  localparam int unsigned CODE_W = 10;  // conversion code width
  localparam int unsigned MV_W   = 12;  // millivolt sample width
  localparam int unsigned NUM_W  = 32;  // dividend width
  localparam int unsigned CNT_W  = 6;   // division step counter
  localparam int unsigned GAIN_W = 8;   // gain factor width

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_RES_LO = 8'h78;  // result low byte
  localparam logic [7:0] OFS_RES_HI = 8'h79;  // result high byte
  localparam logic [7:0] OFS_SEL    = 8'h7C;  // input/reference select
  localparam logic [7:0] OFS_STS    = 8'h70;  // event status, read only
  localparam logic [7:0] OFS_CLR    = 8'h71;  // event clear, write only
  localparam logic [7:0] OFS_ENA    = 8'h72;  // event enable
  localparam logic [7:0] SEL_RST    = 8'h00;  // select reset value
  localparam logic [7:0] BYTE_ZERO  = 8'h00;  // reserved bits / no map

  // ************************************************************
  // select register fields
  // ************************************************************
  localparam int unsigned REF_HI = 7;   // reference field msb
  localparam int unsigned REF_LO = 6;   // reference field lsb
  localparam int unsigned LADJ_B = 5;   // left adjust bit
  localparam int unsigned CHAN_HI = 4;  // channel/gain field msb
  localparam int unsigned EV_DONE = 0;  // done bit in event regs
  localparam int unsigned EV_BUSY = 7;  // busy bit in status reg

  typedef enum logic [1:0] {
    REF_EXT_PIN, REF_SUPPLY, REF_INT_1V1, REF_INT_2V56
  } ref_sel_e;

  // ************************************************************
  // arithmetic constants
  // ************************************************************
  localparam int unsigned SE_SHIFT   = 10;  // times 1024
  localparam int unsigned DIFF_SHIFT = 9;   // times 512
  localparam logic [9:0]  SE_MAX     = 10'h3FF;
  localparam logic [9:0]  DIFF_MAX   = 10'h1FF;
  localparam logic [9:0]  DIFF_MIN   = 10'h200;
  localparam logic [9:0]  CODE_ZERO  = 10'h000;
  localparam logic [7:0]  GAIN_1     = 8'h01;
  localparam logic [7:0]  GAIN_10    = 8'h0A;
  localparam logic [7:0]  GAIN_200   = 8'hC8;
  localparam logic [11:0] INT_1V1_MV  = 12'd1100;
  localparam logic [11:0] INT_2V56_MV = 12'd2560;
  localparam logic [5:0]  DIV_STEPS  = 6'h20;  // one step per bit

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;   // byte address
    logic [DATA_W-1:0] wdata;  // write data
    logic              wr;     // write strobe
    logic              rd;     // read strobe
  } reg_req_s;

  typedef struct packed {
    logic [MV_W-1:0] pos_mv;  // positive / single-ended input
    logic [MV_W-1:0] neg_mv;  // negative differential input
  } sample_s;

endpackage

// [bench/adc_result_monitor.sv]
/* port checker of the converter result block.
   assumes binding onto adc_result_core, a single clock domain. */
`timescale 1ns/1ns
`default_nettype none

module adc_result_monitor
  import adc_result_pkg::*;
#(
  parameter logic [11:0] EXT_REF_MV = 12'd2500, // pin reference
  parameter logic [11:0] SUPPLY_MV  = 12'd3300  // supply reference
) (
  input wire logic                     clk_sys_i,    // system clock
  input wire logic                     sys_rst_i,    // sync reset
  input wire adc_result_pkg::reg_req_s req_i,        // register request
  input wire logic [7:0]               rd_data_o,    // read data
  input wire logic                     conv_start_i, // start pulse
  input wire adc_result_pkg::sample_s  sample_i,     // held samples
  input wire logic                     conv_busy_o,  // converting
  input wire logic [3:0]               ref_path_o,   // reference path
  input wire logic                     int_ref_en_o, // internal ref on
  input wire logic [4:0]               chan_o,       // channel in use
  input wire logic                     irq_o         // interrupt
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  logic [7:0] busy_cnt_r; // busy cycles of the running conversion

  // ************************************************************
  // helper: busy-run length, cleared whenever idle
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !conv_busy_o) begin
      busy_cnt_r <= 8'h00;
    end else begin
      busy_cnt_r <= busy_cnt_r + 8'h01;
    end
  end

  a_read_quiet: assert property (!req_i.rd |=> rd_data_o == 8'h00)
    else $error("read data not zero outside a read answer");
  a_sel_readback: assert property (
    (req_i.wr && req_i.addr == OFS_SEL)
    ##1 (req_i.rd && req_i.addr == OFS_SEL)
    |=> rd_data_o == $past(req_i.wdata, 2))
    else $error("select register did not read back");
  a_start_busy: assert property ((conv_start_i && !conv_busy_o)
    |=> conv_busy_o)
    else $error("start not taken while idle");
  a_busy_length: assert property ($fell(conv_busy_o)
    |-> busy_cnt_r == 8'h20)
    else $error("conversion length wrong");
  a_busy_bound: assert property (conv_busy_o |-> busy_cnt_r < 8'h20)
    else $error("conversion overran");
  a_ref_held: assert property (conv_busy_o ##1 conv_busy_o
    |-> $stable(ref_path_o) && $stable(chan_o))
    else $error("reference or channel moved mid conversion");
  a_ref_onehot: assert property ($onehot(ref_path_o))
    else $error("reference path not one-hot");
  a_int_ref_match: assert property (int_ref_en_o ==
    (ref_path_o[2] || ref_path_o[3]))
    else $error("internal reference enable wrong");
  a_clear_drops_irq: assert property (
    (req_i.wr && req_i.addr == OFS_CLR
    && req_i.wdata[0] && !conv_busy_o) |=> ##1 !irq_o)
    else $error("interrupt stayed after clear");
endmodule

`default_nettype wire

// [bench/analog_src.sv]
/* far-side model: analog source voltages and the start pulse.
   assumes fire() is called from the bench on clk_sys_i. */
`timescale 1ns/1ns
`default_nettype none

module analog_src
  import adc_result_pkg::*;
(
  input  wire logic                    clk_sys_i, // system clock
  output var  logic                    start_o,   // start pulse
  output var  adc_result_pkg::sample_s sample_o   // held voltages
);
  // reference pin is never driven here, so internal refs are safe
  initial begin
    start_o = 1'b0;
    sample_o = '0;
  end

  // voltages stay held after the start, as a real source keeps them
  task automatic fire(input logic [11:0] p, input logic [11:0] n);
    @(posedge clk_sys_i);
    sample_o <= '{p, n};
    start_o <= 1'b1;
    @(posedge clk_sys_i);
    start_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [bench/tb.sv]
/* self-checking bench of the converter result block.
   assumes the package and core are compiled first. */
`timescale 1ns/1ns
`default_nettype none

module tb;
  import adc_result_pkg::*;
  logic       clk_sys_i;    // 10 MHz clock
  logic       sys_rst_i;    // sync reset
  reg_req_s   req_i;        // register request
  sample_s    sample_i;     // from the source model
  logic       conv_start_i; // from the source model
  logic [7:0] rd_data_o;    // read data
  logic       conv_busy_o;  // converting
  logic [3:0] ref_path_o;   // reference path
  logic       int_ref_en_o; // internal ref on
  logic [4:0] chan_o;       // channel in use
  logic       irq_o;        // interrupt
  int         n_errors;     // mismatches
  int         cmp_count;    // compares

  always #50 clk_sys_i = ~clk_sys_i;

  adc_result_core #(.EXT_REF_MV(12'd2500), .SUPPLY_MV(12'd3300))
    adc_result_core_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .rd_data_o(rd_data_o), .conv_start_i(conv_start_i),
    .sample_i(sample_i), .conv_busy_o(conv_busy_o),
    .ref_path_o(ref_path_o), .int_ref_en_o(int_ref_en_o),
    .chan_o(chan_o), .irq_o(irq_o));

  analog_src analog_src_inst (.clk_sys_i(clk_sys_i),
    .start_o(conv_start_i), .sample_o(sample_i));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i) req_i <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys_i) req_i <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i) req_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys_i) req_i <= '0;
    #1 chk(rd_data_o, e);
  endtask
  task automatic fin();
    repeat (2) @(posedge clk_sys_i);
    #1;
    for (int i = 0; i < 40 && conv_busy_o !== 1'b0; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    chk(conv_busy_o, 1'b0);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    #1 chk(ref_path_o, 4'h1);
    rdc(OFS_SEL, 8'h00);
    rdc(8'h55, 8'h00);
    rdc(OFS_CLR, 8'h00);
    @(posedge clk_sys_i) req_i <= '{OFS_SEL, 8'hA5, 1'b1, 1'b0};
    @(posedge clk_sys_i) req_i <= '{OFS_SEL, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys_i) req_i <= '0;
    #1 chk(rd_data_o, 8'hA5);
    for (int r = 0; r < 4; r++) begin
      wr(OFS_SEL, {r[1:0], 6'h15});
      settle();
      chk(ref_path_o, 4'h1 << r);
      chk(int_ref_en_o, r[1]);
      rdc(OFS_SEL, {r[1:0], 6'h15});
    end
  endtask
  // differential, reference change mid run, both alignments
  task automatic t_diff();
    wr(OFS_ENA, 8'h01);
    wr(OFS_SEL, 8'hED); // 2.56 V internal, left adjust, differential at 10x
    analog_src_inst.fire(12'd300, 12'd500);
    wr(OFS_SEL, 8'h2D);
    settle();
    chk(ref_path_o, 4'h8);
    fin();
    settle();
    chk(ref_path_o, 4'h1);
    chk(chan_o, 5'h0D);
    chk(irq_o, 1'b1);
    rdc(OFS_STS, 8'h01);
    rdc(OFS_RES_LO, 8'h00);
    rdc(OFS_RES_HI, 8'h9C);
    wr(OFS_SEL, 8'h0D);
    rdc(OFS_RES_LO, 8'h70);
    rdc(OFS_RES_HI, 8'h02);
    wr(OFS_CLR, 8'h01);
    settle();
    chk(irq_o, 1'b0);
  endtask
  // single-ended codes, right aligned, interrupt masked
  task automatic t_single();
    logic [7:0]  sl [4] = '{8'h40, 8'hC1, 8'h87, 8'h03};
    logic [11:0] pv [4] = '{12'd3300, 12'd1000, 12'd0, 12'd1250};
    logic [9:0]  ev [4] = '{10'h3FF, 10'h190, 10'h000, 10'h200};
    wr(OFS_ENA, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_SEL, sl[k]);
      analog_src_inst.fire(pv[k], 12'd0);
      fin();
      rdc(OFS_RES_LO, ev[k][7:0]);
      rdc(OFS_RES_HI, {6'h00, ev[k][9:8]});
      rdc(OFS_STS, 8'h01);
      chk(irq_o, 1'b0);
      wr(OFS_CLR, 8'h01);
    end
  endtask
  // low read freezes the pair until the high read; clamped codes
  task automatic t_freeze();
    wr(OFS_SEL, 8'hF0); // 2.56 V internal with differential
    analog_src_inst.fire(12'd2560, 12'd0);
    fin();
    rdc(OFS_RES_LO, 8'hC0);
    analog_src_inst.fire(12'd0, 12'd2560);
    fin();
    rdc(OFS_RES_HI, 8'h7F);
    rdc(OFS_RES_LO, 8'h00);
    rdc(OFS_RES_HI, 8'h80);
  endtask
  // 200x gain and a single-ended tail code, right aligned
  task automatic t_codes();
    wr(OFS_SEL, 8'hCF); // 2.56 V internal with differential
    analog_src_inst.fire(12'd510, 12'd500);
    fin();
    rdc(OFS_RES_LO, 8'h90);
    rdc(OFS_RES_HI, 8'h01);
    wr(OFS_SEL, 8'h5E);
    analog_src_inst.fire(12'd1650, 12'd1000);
    fin();
    rdc(OFS_RES_LO, 8'h00);
    rdc(OFS_RES_HI, 8'h02);
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_errors++;
    close_out();
  end

  initial begin
    clk_sys_i = 1'b0;
    sys_rst_i = 1'b1;
    req_i = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_diff();
    t_single();
    t_freeze();
    t_codes();
    close_out();
  end
endmodule

bind adc_result_core adc_result_monitor #(
  .EXT_REF_MV(EXT_REF_MV), .SUPPLY_MV(SUPPLY_MV)
) adc_result_monitor_inst (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
  .rd_data_o(rd_data_o), .conv_start_i(conv_start_i),
  .sample_i(sample_i), .conv_busy_o(conv_busy_o),
  .ref_path_o(ref_path_o), .int_ref_en_o(int_ref_en_o),
  .chan_o(chan_o), .irq_o(irq_o));

`default_nettype wire
